/* verilog/bdf_pkg.sv */
`default_nettype none
package bdf_pkg;

  // --------------------------------------------------------------------------
  // Time base
  // --------------------------------------------------------------------------
  localparam int CLK_PERIOD_NS    = 40;
  localparam int TICK_NS          = 1000;
  localparam int CYC_PER_TICK     = TICK_NS / CLK_PERIOD_NS;
  localparam int SUBTICK_DIV      = 64;
  localparam int SUB_STEP_INT     = SUBTICK_DIV / CYC_PER_TICK;
  localparam int SUB_STEP_REM     = SUBTICK_DIV % CYC_PER_TICK;
  localparam int TICK_W           = 26;
  localparam int MS_W             = 26;
  localparam int SUB_W            = 6;
  localparam int CYC_W            = 6;
  localparam int CFG_W            = 16;

  // --------------------------------------------------------------------------
  // Framing
  // --------------------------------------------------------------------------
  localparam int         FRAME_STEP_US    = 500;
  localparam int         FRAME_STEP_TICKS = FRAME_STEP_US * 1000 / TICK_NS;
  localparam logic [3:0] FRAME_CODE_MIN   = 4'h1;
  localparam logic [3:0] FRAME_CODE_MAX   = 4'hA;
  localparam int         FIFO_DEPTH       = 8;
  localparam int         NUM_MOD          = 3;
  localparam logic [2:0] GRP_SEQ_LAST     = 3'h5;
  localparam logic [1:0] MOD_QPSK         = 2'h0;
  localparam logic [1:0] MOD_QAM16        = 2'h1;
  localparam logic [1:0] MOD_QAM64        = 2'h2;
  localparam logic [1:0] BURST_CODE_CTRL  = 2'h0;
  localparam logic       FEC_ROBUST       = 1'b0;
  localparam logic       PHY_TDD          = 1'b0;
  localparam logic       PHY_FDD          = 1'b1;

  typedef logic [MS_W-1:0] bdf_ms_t;

  typedef enum logic [3:0] {
    REC_PREAMBLE = 4'h1,
    REC_DLMAP    = 4'h2,
    REC_BSID     = 4'h3,
    REC_GROUP    = 4'h4,
    REC_GAP      = 4'h5,
    REC_ULMAP    = 4'h6,
    REC_ACK      = 4'h7,
    REC_DCD      = 4'h8,
    REC_UCD      = 4'h9
  } bdf_kind_e;

  typedef struct packed {
    bdf_kind_e  kind;
    logic [1:0] mod;
    logic       short_pre;
    logic       fec;
    bdf_ms_t    payload;
  } bdf_rec_s;

  localparam int REC_W = $bits(bdf_rec_s);

  // --------------------------------------------------------------------------
  // Wrap-tolerant mini-slot arithmetic; clamped frame length in ticks
  // --------------------------------------------------------------------------
  function automatic bdf_ms_t ms_add(input bdf_ms_t a, input bdf_ms_t b);
    return a + b;
  endfunction

  function automatic logic ms_not_before(input bdf_ms_t a, input bdf_ms_t b);
    bdf_ms_t diff;
    diff = b - a;
    return ~diff[MS_W-1];
  endfunction

  function automatic logic [TICK_W-1:0] frame_ticks(input logic [3:0] code);
    logic [TICK_W-1:0] c;
    c = TICK_W'(code);
    if (code < FRAME_CODE_MIN) begin
      c = TICK_W'(FRAME_CODE_MIN);
    end
    if (code > FRAME_CODE_MAX) begin
      c = TICK_W'(FRAME_CODE_MAX);
    end
    return TICK_W'(c * TICK_W'(FRAME_STEP_TICKS));
  endfunction

endpackage
`default_nettype wire

/* verilog/bdf_link_if.sv */
`timescale 1ns/1ns
`default_nettype none
interface bdf_link_if;
  logic               valid;
  logic               ready;
  bdf_pkg::bdf_rec_s  rec;

  modport framer   (output valid, output rec, input ready);
  modport receiver (input valid, input rec, output ready);
endinterface
`default_nettype wire

/* verilog/bdf_framer.sv */
`timescale 1ns/1ns
`default_nettype none

// ----------------------------------------------------------------------------
// Record FIFO
// ----------------------------------------------------------------------------
module bdf_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             ref_clk_i,
  input  wire logic             rstn_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wr;
    logic [AW-1:0]               rd;
    logic [AW:0]                 cnt;
  } bdf_fifo_s;

  bdf_fifo_s q;
  bdf_fifo_s d;
  logic      push;
  logic      pop;

  always_comb begin
    d    = q;
    push = in_valid_i && (q.cnt != FULL_CNT);
    pop  = out_ready_i && (q.cnt != '0);
    if (push) begin
      d.mem[q.wr] = in_data_i;
      d.wr        = q.wr + 1'b1;
    end
    if (pop) begin
      d.rd = q.rd + 1'b1;
    end
    d.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign in_ready_o  = (q.cnt != FULL_CNT);
  assign out_valid_o = (q.cnt != '0);
  assign out_data_o  = q.mem[q.rd];
endmodule

// ----------------------------------------------------------------------------
// Base station downlink framer and time base
// ----------------------------------------------------------------------------
module bdf_framer (
  input  wire logic                         ref_clk_i,
  input  wire logic                         rstn_i,
  input  wire logic                         en_i,
  input  wire logic                         phy_type_i,
  input  wire logic                         subburst_i,
  input  wire logic [3:0]                   frame_code_i,
  input  wire logic [bdf_pkg::CFG_W-1:0]    ticks_per_ms_i,
  input  wire logic [bdf_pkg::CFG_W-1:0]    ctrl_len_i,
  input  wire logic [2:0][bdf_pkg::CFG_W-1:0] grp_len_i,
  input  wire logic [2:0]                   fec_split_i,
  input  wire logic [bdf_pkg::CFG_W-1:0]    ttg_len_i,
  input  wire logic [2:0]                   ul_chan_cnt_i,
  input  wire logic                         send_dcd_i,
  input  wire logic                         send_ucd_i,
  input  wire logic [bdf_pkg::CFG_W-1:0]    bs_id_i,
  input  wire bdf_pkg::bdf_ms_t             ack_ms_i,
  output logic      [bdf_pkg::TICK_W-1:0]   tick_o,
  output logic      [bdf_pkg::SUB_W-1:0]    subtick_o,
  output bdf_pkg::bdf_ms_t                  minislot_o,
  output logic                              frame_start_o,
  output logic                              frame_misalign_o,
  output logic                              frame_overrun_o,
  output logic                              busy_o,
  bdf_link_if.framer                        link
);
  import bdf_pkg::*;

  typedef enum logic [9:0] {
    S_IDLE  = 10'b0000000001,
    S_PRE   = 10'b0000000010,
    S_DLMAP = 10'b0000000100,
    S_BSID  = 10'b0000001000,
    S_GROUP = 10'b0000010000,
    S_GAP   = 10'b0000100000,
    S_ULMAP = 10'b0001000000,
    S_ACK   = 10'b0010000000,
    S_DCD   = 10'b0100000000,
    S_UCD   = 10'b1000000000
  } bdf_state_e;

  typedef struct packed {
    logic [CYC_W-1:0]  cyc;
    logic [SUB_W-1:0]  sub;
    logic [CYC_W-1:0]  rem;
    logic [TICK_W-1:0] tick;
    logic [CFG_W-1:0]  msdiv;
    bdf_ms_t           ms;
    logic [TICK_W-1:0] ftick;
    bdf_state_e        st;
    logic [TICK_W-1:0] ts;
    bdf_ms_t           frame_ms;
    bdf_ms_t           grp_ms;
    logic [2:0]        grp_idx;
    logic [2:0]        chan;
    logic              frame_start;
    logic              misalign;
    logic              overrun;
    logic              busy;
  } bdf_framer_s;

  bdf_framer_s       q;
  bdf_framer_s       d;
  bdf_rec_s          rec;
  logic              push;
  logic              fifo_ready;
  logic [REC_W-1:0]  fifo_out;
  logic              tick_now;
  logic [CYC_W-1:0]  rem_sum;
  logic              carry;
  logic [CFG_W-1:0]  m_div;
  logic [1:0]        gmod;
  logic [CFG_W-1:0]  gfull;
  logic [CFG_W-1:0]  glen;
  logic [3:0]        fcode;

  // --------------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------------
  always_comb begin
    d             = q;
    d.frame_start = 1'b0;
    d.overrun     = 1'b0;
    rec           = '0;
    rec.mod       = BURST_CODE_CTRL;
    rec.fec       = FEC_ROBUST;
    push          = 1'b0;
    tick_now      = (q.cyc == CYC_W'(CYC_PER_TICK - 1));
    rem_sum       = q.rem + CYC_W'(SUB_STEP_REM);
    carry         = (rem_sum >= CYC_W'(CYC_PER_TICK));
    m_div         = (ticks_per_ms_i == '0) ? CFG_W'(1) : ticks_per_ms_i;
    // The preamble must announce the clamped code, since that is the one that sets the period.
    fcode         = (frame_code_i < FRAME_CODE_MIN) ? FRAME_CODE_MIN : frame_code_i;
    fcode         = (fcode > FRAME_CODE_MAX) ? FRAME_CODE_MAX : fcode;
    gmod          = subburst_i ? (2'(NUM_MOD - 1) - q.grp_idx[2:1]) : q.grp_idx[2:1];
    gfull         = grp_len_i[gmod];
    if (!fec_split_i[gmod]) begin
      glen = q.grp_idx[0] ? '0 : gfull;
    end else begin
      glen = q.grp_idx[0] ? (gfull >> 1) : (gfull - (gfull >> 1));
    end

    // Sub-tick phase advances 64/25 per cycle, carried exactly so that a tick is 64 sub-ticks.
    if (tick_now) begin
      d.cyc  = '0;
      d.sub  = '0;
      d.rem  = '0;
      d.tick = q.tick + 1'b1;
      if (q.msdiv >= m_div - 1'b1) begin
        d.msdiv = '0;
        d.ms    = ms_add(q.ms, MS_W'(1));
      end else begin
        d.msdiv = q.msdiv + 1'b1;
      end
      if (q.ftick >= frame_ticks(frame_code_i) - 1'b1) begin
        d.ftick       = '0;
        d.frame_start = 1'b1;
        d.ts          = d.tick;
        d.frame_ms    = d.ms;
        d.grp_ms      = ms_add(d.ms, MS_W'(ctrl_len_i));
        d.misalign    = (d.msdiv != '0);
        if (q.st != S_IDLE) begin
          d.overrun = 1'b1;
        end else if (en_i) begin
          d.st = S_PRE;
        end
      end else begin
        d.ftick = q.ftick + 1'b1;
      end
    end else begin
      d.cyc = q.cyc + 1'b1;
      d.rem = carry ? (rem_sum - CYC_W'(CYC_PER_TICK)) : rem_sum;
      d.sub = q.sub + SUB_W'(SUB_STEP_INT) + SUB_W'(carry);
    end

    // A stalled FIFO holds the sequencer; a frame that starts while it is still busy is dropped.
    unique case (q.st)
      S_IDLE: begin
      end
      S_PRE: begin
        rec.kind    = REC_PREAMBLE;
        rec.payload = bdf_ms_t'({phy_type_i, fcode});
        push        = 1'b1;
        if (fifo_ready) d.st = S_DLMAP;
      end
      S_DLMAP: begin
        rec.kind    = REC_DLMAP;
        rec.payload = bdf_ms_t'(q.ts);
        push        = 1'b1;
        if (fifo_ready) d.st = S_BSID;
      end
      S_BSID: begin
        rec.kind    = REC_BSID;
        rec.payload = bdf_ms_t'(bs_id_i);
        push        = 1'b1;
        if (fifo_ready) begin
          d.st      = S_GROUP;
          d.grp_idx = '0;
        end
      end
      S_GROUP: begin
        rec.kind      = REC_GROUP;
        rec.mod       = gmod;
        rec.fec       = q.grp_idx[0];
        rec.short_pre = subburst_i;
        rec.payload   = q.grp_ms;
        push          = (glen != '0);
        if (!push || fifo_ready) begin
          d.grp_ms = ms_add(q.grp_ms, MS_W'(glen));
          d.grp_idx = q.grp_idx + 1'b1;
          d.chan    = '0;
          if (q.grp_idx == GRP_SEQ_LAST) begin
            d.st = (phy_type_i == PHY_TDD) ? S_GAP : S_ULMAP;
          end
        end
      end
      S_GAP: begin
        rec.kind    = REC_GAP;
        rec.payload = q.grp_ms;
        push        = 1'b1;
        if (fifo_ready) d.st = S_ULMAP;
      end
      S_ULMAP: begin
        rec.kind    = REC_ULMAP;
        rec.payload = (phy_type_i == PHY_TDD) ? ms_add(q.grp_ms, MS_W'(ttg_len_i)) : q.frame_ms;
        push        = (q.chan != ul_chan_cnt_i);
        if (!push) begin
          d.st = S_DCD;
        end else if (fifo_ready) begin
          d.st = S_ACK;
        end
      end
      S_ACK: begin
        rec.kind    = REC_ACK;
        rec.payload = ack_ms_i;
        push        = 1'b1;
        if (fifo_ready) begin
          d.st   = S_ULMAP;
          d.chan = q.chan + 1'b1;
        end
      end
      S_DCD: begin
        rec.kind = REC_DCD;
        push     = send_dcd_i;
        if (!push || fifo_ready) d.st = S_UCD;
      end
      S_UCD: begin
        rec.kind = REC_UCD;
        push     = send_ucd_i;
        if (!push || fifo_ready) d.st = S_IDLE;
      end
      default: begin
        d.st = S_IDLE;
      end
    endcase
    d.busy = (d.st != S_IDLE);
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      q    <= '0;
      q.st <= S_IDLE;
    end else begin
      q <= d;
    end
  end

  // --------------------------------------------------------------------------
  // Link buffer
  // --------------------------------------------------------------------------
  bdf_fifo #(
    .WIDTH (REC_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .ref_clk_i   (ref_clk_i),
    .rstn_i      (rstn_i),
    .in_valid_i  (push),
    .in_ready_o  (fifo_ready),
    .in_data_i   (rec),
    .out_valid_o (link.valid),
    .out_ready_i (link.ready),
    .out_data_o  (fifo_out)
  );

  assign link.rec         = bdf_rec_s'(fifo_out);
  assign tick_o           = q.tick;
  assign subtick_o        = q.sub;
  assign minislot_o       = q.ms;
  assign frame_start_o    = q.frame_start;
  assign frame_misalign_o = q.misalign;
  assign frame_overrun_o  = q.overrun;
  assign busy_o           = q.busy;
endmodule
`default_nettype wire

/* verilog/bdf_receiver.sv */
`timescale 1ns/1ns
`default_nettype none

// ----------------------------------------------------------------------------
// Subscriber side frame decoder and order checker
// ----------------------------------------------------------------------------
module bdf_receiver (
  input  wire logic                       ref_clk_i,
  input  wire logic                       rstn_i,
  input  wire logic                       user_ready_i,
  output logic                            frame_sync_o,
  output logic                            phy_type_o,
  output logic      [3:0]                 frame_code_o,
  output logic      [bdf_pkg::TICK_W-1:0] timestamp_o,
  output logic      [bdf_pkg::CFG_W-1:0]  bs_id_o,
  output logic                            grp_valid_o,
  output logic      [1:0]                 grp_mod_o,
  output logic                            grp_fec_o,
  output logic                            grp_short_pre_o,
  output bdf_pkg::bdf_ms_t                grp_start_o,
  output bdf_pkg::bdf_ms_t                gap_start_o,
  output bdf_pkg::bdf_ms_t                ul_start_o,
  output bdf_pkg::bdf_ms_t                ack_ms_o,
  output logic                            order_err_o,
  bdf_link_if.receiver                    link
);
  import bdf_pkg::*;

  typedef enum logic [5:0] {
    P_WAIT  = 6'b000001,
    P_DLMAP = 6'b000010,
    P_BSID  = 6'b000100,
    P_ELEM  = 6'b001000,
    P_ULMAP = 6'b010000,
    P_DESC  = 6'b100000
  } bdf_phase_e;

  typedef struct packed {
    logic              ready;
    bdf_phase_e        ph;
    logic              have_grp;
    logic [2:0]        last_rank;
    bdf_ms_t           last_start;
    logic              frame_sync;
    logic              phy;
    logic [3:0]        code;
    logic [TICK_W-1:0] ts;
    logic [CFG_W-1:0]  bsid;
    logic              grp_valid;
    logic [1:0]        grp_mod;
    logic              grp_fec;
    logic              grp_pre;
    bdf_ms_t           grp_start;
    bdf_ms_t           gap;
    bdf_ms_t           ul_start;
    bdf_ms_t           ack;
    logic              err;
  } bdf_receiver_s;

  bdf_receiver_s q;
  bdf_receiver_s d;
  bdf_rec_s      r;
  logic          take;
  logic          bad;

  always_comb begin
    d            = q;
    d.ready      = user_ready_i;
    d.frame_sync = 1'b0;
    d.grp_valid  = 1'b0;
    d.err        = 1'b0;
    r            = link.rec;
    take         = link.valid && q.ready;
    bad          = 1'b0;
    if (take) begin
      if (r.kind != REC_GROUP && (r.mod != BURST_CODE_CTRL || r.fec != FEC_ROBUST)) begin
        bad = 1'b1;
      end
      unique case (r.kind)
        REC_PREAMBLE: begin
          bad          = bad || (q.ph == P_DLMAP) || (q.ph == P_BSID) || (q.ph == P_ELEM);
          d.ph         = P_DLMAP;
          d.frame_sync = 1'b1;
          d.phy        = r.payload[4];
          d.code       = r.payload[3:0];
          bad          = bad || (r.payload[3:0] < FRAME_CODE_MIN) || (r.payload[3:0] > FRAME_CODE_MAX);
        end
        REC_DLMAP: begin
          bad  = bad || (q.ph != P_DLMAP);
          d.ph = P_BSID;
          d.ts = TICK_W'(r.payload);
        end
        REC_BSID: begin
          bad        = bad || (q.ph != P_BSID);
          d.ph       = P_ELEM;
          d.bsid     = CFG_W'(r.payload);
          d.have_grp = 1'b0;
        end
        REC_GROUP: begin
          bad = bad || (q.ph != P_ELEM);
          if (q.have_grp) begin
            bad = bad || !ms_not_before(q.last_start, r.payload);
            if (!r.short_pre) begin
              bad = bad || ({r.mod, r.fec} < q.last_rank);
            end
          end
          d.have_grp   = 1'b1;
          d.last_rank  = {r.mod, r.fec};
          d.last_start = r.payload;
          d.grp_valid  = 1'b1;
          d.grp_mod    = r.mod;
          d.grp_fec    = r.fec;
          d.grp_pre    = r.short_pre;
          d.grp_start  = r.payload;
        end
        REC_GAP: begin
          bad   = bad || (q.ph != P_ELEM) || (q.phy != PHY_TDD);
          d.gap = r.payload;
        end
        REC_ULMAP: begin
          bad = bad || !((q.ph == P_ELEM) || (q.ph == P_ULMAP));
          if (q.phy == PHY_TDD) begin
            bad = bad || !ms_not_before(q.gap, r.payload);
          end
          d.ph       = P_ULMAP;
          d.ul_start = r.payload;
        end
        REC_ACK: begin
          bad   = bad || (q.ph != P_ULMAP);
          d.ack = r.payload;
        end
        REC_DCD, REC_UCD: begin
          bad  = bad || !((q.ph == P_ELEM) || (q.ph == P_ULMAP) || (q.ph == P_DESC));
          d.ph = P_DESC;
        end
        default: begin
          bad = 1'b1;
        end
      endcase
    end
    d.err = bad;
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      q    <= '0;
      q.ph <= P_WAIT;
    end else begin
      q <= d;
    end
  end

  assign link.ready      = q.ready;
  assign frame_sync_o    = q.frame_sync;
  assign phy_type_o      = q.phy;
  assign frame_code_o    = q.code;
  assign timestamp_o     = q.ts;
  assign bs_id_o         = q.bsid;
  assign grp_valid_o     = q.grp_valid;
  assign grp_mod_o       = q.grp_mod;
  assign grp_fec_o       = q.grp_fec;
  assign grp_short_pre_o = q.grp_pre;
  assign grp_start_o     = q.grp_start;
  assign gap_start_o     = q.gap;
  assign ul_start_o      = q.ul_start;
  assign ack_ms_o        = q.ack;
  assign order_err_o     = q.err;
endmodule
`default_nettype wire

/* verification/bdf_link_monitor.sv */
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------------------------------------------
// Link order checker
// ----------------------------------------------------------------------------
module bdf_link_monitor (
  input  wire logic              ref_clk_i,
  input  wire logic              rstn_i,
  input  wire logic              valid,
  input  wire logic              ready,
  input  wire bdf_pkg::bdf_rec_s rec
);
  import bdf_pkg::*;
  logic     take;
  bdf_rec_s last_q;
  logic     phy_q;
  assign take = valid && ready;
  // Only taken records count, so a stalled record is never judged twice.
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      last_q <= '0;
      phy_q  <= 1'b0;
    end else if (take) begin
      last_q <= rec;
      if (rec.kind == REC_PREAMBLE) begin
        phy_q <= rec.payload[4];
      end
    end
  end
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);
  property p_hold; valid && !ready |=> valid && $stable(rec); endproperty
  a_hold: assert property (p_hold) else $error("record changed while stalled");
  property p_ctrl; take && rec.kind != REC_GROUP |-> rec.mod == BURST_CODE_CTRL && rec.fec == FEC_ROBUST; endproperty
  a_ctrl: assert property (p_ctrl) else $error("control record not robust");
  property p_dlmap; take && rec.kind == REC_DLMAP |-> last_q.kind == REC_PREAMBLE; endproperty
  a_dlmap: assert property (p_dlmap) else $error("map without preamble");
  property p_stn; take && rec.kind == REC_BSID |-> last_q.kind == REC_DLMAP; endproperty
  a_stn: assert property (p_stn) else $error("station id out of place");
  property p_ack; take && last_q.kind == REC_ULMAP |-> rec.kind == REC_ACK; endproperty
  a_ack: assert property (p_ack) else $error("uplink map without ack");
  property p_desc; take && rec.kind == REC_ULMAP |-> !(last_q.kind inside {REC_DCD, REC_UCD}); endproperty
  a_desc: assert property (p_desc) else $error("uplink map after descriptor");
  property p_rank;
    take && rec.kind == REC_GROUP && last_q.kind == REC_GROUP && !rec.short_pre
      |-> {rec.mod, rec.fec} > {last_q.mod, last_q.fec};
  endproperty
  a_rank: assert property (p_rank) else $error("group robustness order");
  property p_time;
    take && rec.kind == REC_GROUP && last_q.kind == REC_GROUP
      |-> ms_not_before(last_q.payload, rec.payload) && rec.payload != last_q.payload;
  endproperty
  a_time: assert property (p_time) else $error("group start not increasing");
  property p_gap; take && rec.kind == REC_GAP |-> phy_q == PHY_TDD; endproperty
  a_gap: assert property (p_gap) else $error("gap outside tdd");
  property p_code; take && rec.kind == REC_PREAMBLE |-> rec.payload[3:0] inside {[4'h1:4'hA]}; endproperty
  a_code: assert property (p_code) else $error("bad frame code");
endmodule
`default_nettype wire

/* verification/burst_downlink_framer_timebase_tb.sv */
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------------------------------------------
// Framer to receiver bench
// ----------------------------------------------------------------------------
module burst_downlink_framer_timebase_tb;
  import bdf_pkg::*;
  logic                  ref_clk_i, rstn_i, phy, sb, d_desc, u_desc, urdy, fst, mis, ovr, busy, rphy, gv, gsp, oerr;
  logic [CFG_W-1:0]      ctl, turn, stn, r_stn;
  logic [2:0][CFG_W-1:0] gl;
  logic [2:0]            fs, ulc;
  logic                  fsn, gf;
  logic [1:0]            gm;
  logic [3:0]            rcode, fc;
  logic [SUB_W-1:0]      sub;
  logic [TICK_W-1:0]     tick, ts, lt;
  bdf_ms_t               ack, gs, ul, rack, slot, gst;
  int                    errors, checked, cyc, ng, nsy, ph, f;
  integer                seed = 32'h3F29;
  bdf_link_if u_bdf_link_if ();
  bdf_framer u_bdf_framer (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .en_i(1'b1), .phy_type_i(phy),
    .subburst_i(sb), .frame_code_i(fc), .ticks_per_ms_i(16'h000A), .ctrl_len_i(ctl), .grp_len_i(gl),
    .fec_split_i(fs), .ttg_len_i(turn), .ul_chan_cnt_i(ulc), .send_dcd_i(d_desc), .send_ucd_i(u_desc),
    .bs_id_i(stn), .ack_ms_i(ack), .tick_o(tick), .subtick_o(sub), .minislot_o(slot), .frame_start_o(fst),
    .frame_misalign_o(mis), .frame_overrun_o(ovr), .busy_o(busy), .link(u_bdf_link_if));
  bdf_receiver u_bdf_receiver (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .user_ready_i(urdy), .frame_sync_o(fsn),
    .phy_type_o(rphy), .frame_code_o(rcode), .timestamp_o(ts), .bs_id_o(r_stn), .grp_valid_o(gv),
    .grp_mod_o(gm), .grp_fec_o(gf), .grp_short_pre_o(gsp), .grp_start_o(gst), .gap_start_o(gs), .ul_start_o(ul),
    .ack_ms_o(rack), .order_err_o(oerr), .link(u_bdf_link_if));
  bdf_link_monitor u_bdf_link_monitor (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .valid(u_bdf_link_if.valid),
    .ready(u_bdf_link_if.ready), .rec(u_bdf_link_if.rec));
  function automatic logic [31:0] n_grp();
    int n = 0;
    for (int i = 0; i < 3; i++) begin
      if (gl[i] != 0) begin
        n += fs[i] ? 2 : 1;
      end
    end
    return n;
  endfunction
  // Expected n-th group of frame f as {mod, fec, start}; empty halves are never sent.
  function automatic logic [31:0] grp_at(input int n);
    int m;
    int len;
    int at;
    at = f * 50 + ctl;
    for (int i = 0; i < 6; i++) begin
      m = sb ? 2 - i / 2 : i / 2;
      len = (i % 2) ? (fs[m] ? gl[m] / 2 : 0) : (fs[m] ? gl[m] - gl[m] / 2 : gl[m]);
      if (len != 0) begin
        if (n == 0) begin
          return {m[1:0], 1'(i % 2), bdf_ms_t'(at)};
        end
        n--;
        at += len;
      end
    end
    return '1;
  endfunction
  function automatic bdf_ms_t gap_at(input int f);
    return bdf_ms_t'(f * 50) + ctl + gl[0] + gl[1] + gl[2];
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    checked++;
    if (seen !== want) begin
      errors++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, want);
    end
  endtask
  task automatic wrap_up();
    if (errors == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    ref_clk_i = 1'b0;
    forever #20 ref_clk_i = ~ref_clk_i;
  end
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 90000) begin
      errors++;
      wrap_up();
    end
  end
  always @(negedge ref_clk_i) begin
    if (rstn_i) begin
      chk(oerr, 0);
      chk(ovr, 0);
      if (fsn === 1'b1) begin
        nsy++;
      end
      if (gv === 1'b1) begin
        chk({gm, gf, gst}, grp_at(ng));
        ng++;
        chk(gsp, sb);
      end
      // The first tick is skipped: its length depends on where reset was released.
      if (tick !== lt) begin
        if (tick > 1) begin
          chk(ph, CYC_PER_TICK - 1);
        end
        ph = 0;
      end else begin
        ph++;
      end
      lt = tick;
      if (tick != 0) begin
        chk(sub, (ph * SUBTICK_DIV) / CYC_PER_TICK);
      end
    end
  end
  initial begin
    {rstn_i, urdy, phy, sb, d_desc, u_desc, ctl, turn, stn, gl, fs, ulc, ack, fc} = '0;
    repeat (6) @(negedge ref_clk_i);
    rstn_i = 1'b1;
    for (f = 1; f <= 5; f++) begin
      // Frame code 0 is out of range and must run and be announced as code 1.
      {phy, sb, d_desc, u_desc, fs, fc[0]} = 8'($random(seed));
      ctl = CFG_W'($random(seed) & 15);
      turn = CFG_W'($random(seed) & 7);
      stn = CFG_W'($random(seed));
      ack = bdf_ms_t'($random(seed));
      ulc = 3'(($random(seed) & 3) | 1);
      for (int i = 0; i < 3; i++) begin
        gl[i] = CFG_W'(($random(seed) & 3) * 3);
      end
      // First frame is the busiest case: every group split, three uplink maps.
      if (f == 1) begin
        {phy, sb, fs, ulc, gl[1]} = {2'b00, 3'h7, 3'h3, 16'h0006};
      end
      do @(negedge ref_clk_i); while (fst !== 1'b1);
      ng = 0;
      nsy = 0;
      urdy = 1'b0;
      repeat (40) @(negedge ref_clk_i);
      chk(u_bdf_link_if.valid, 1);
      while (busy !== 1'b0 || u_bdf_link_if.valid !== 1'b0) begin
        urdy = 1'($random(seed));
        @(negedge ref_clk_i);
      end
      repeat (3) @(negedge ref_clk_i);
      while (sub < 6'h20) @(negedge ref_clk_i);
      chk(ts, f * 500);
      chk(rcode, 1);
      chk(nsy, 1);
      chk(rphy, phy);
      chk(r_stn, stn);
      chk(rack, ack);
      chk(ng, n_grp());
      chk(mis, 0);
      chk(slot, tick / 10);
      if (phy == PHY_TDD) begin
        chk(gs, gap_at(f));
        chk(ul, gap_at(f) + turn);
      end else begin
        chk(ul, f * 50);
      end
    end
    wrap_up();
  end
endmodule
`default_nettype wire
